/* design/spr_switch_partition_reconfig.sv */
// spr_switch_partition_reconfig: port mode / partition reconfiguration control.
// assumes synchronous strobes from one register master; link pins are levels.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module spr_switch_partition_reconfig #(
    parameter int unsigned NUM_PORTS   = 16,
    parameter int unsigned NUM_PARTS   = 8,
    parameter int unsigned MC_NORM_CYC = spr_pkg::MC_NO_RESET_CYC,
    parameter int unsigned MC_RST_CYC  = spr_pkg::MC_RESET_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // link control
    output logic      [NUM_PORTS-1:0] link_down,
    output logic      [NUM_PORTS-1:0] link_retrain_detect,
    output logic      [NUM_PORTS-1:0] port_enabled,
    output logic      [NUM_PORTS-1:0] port_is_upstream,
    output logic                      reconfig_busy
);

    if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
        $error("NUM_PORTS must be 1..16");
    end
    if (NUM_PARTS < 1 || NUM_PARTS > 8) begin : g_bad_parts
        $error("NUM_PARTS must be 1..8");
    end
    if (MC_NORM_CYC < 1 || MC_RST_CYC < 1) begin : g_bad_lat
        $error("latencies must be nonzero");
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [2:0]  mode_q [NUM_PORTS];
    logic [2:0]  mode_d [NUM_PORTS];
    logic [2:0]  partition_select_q [NUM_PORTS];
    logic [2:0]  partition_select_d [NUM_PORTS];
    logic [1:0]  mca_q  [NUM_PORTS];
    logic [1:0]  mca_d  [NUM_PORTS];
    logic        pstate_q [NUM_PARTS];
    logic        pstate_d [NUM_PARTS];
    logic [15:0] tmr_q [4];
    logic [15:0] tmr_d [4];
    logic [7:0]  cap_pm_q, cap_pm_d;
    logic [7:0]  cap_vc_q, cap_vc_d;
    logic [31:0] rdata_q, rdata_d;

    // ****************************************************************
    // reconfiguration sequencer
    // ****************************************************************
    spr_pkg::spr_state_t state_q, state_d;
    logic [31:0]          cnt_q, cnt_d;
    logic [3:0]           tgt_q, tgt_d;     // port under change
    logic                 tgt_rst_q, tgt_rst_d;
    logic [NUM_PORTS-1:0] down_q, down_d;
    logic [NUM_PORTS-1:0] en_q, en_d;
    logic [NUM_PORTS-1:0] up_q, up_d;
    logic [NUM_PORTS-1:0] retr_q, retr_d;
    logic                 busy_q, busy_d;
    logic [4:0]           retr_cnt_q [NUM_PORTS];
    logic [4:0]           retr_cnt_d [NUM_PORTS];

    logic       wr_port, wr_partition_select;
    logic [3:0] widx;
    logic [2:0] new_mode;
    logic [1:0] new_mca;

    always_comb begin
        wr_port  = reg_wr && reg_addr < spr_pkg::ADDR_PARTITION_SELECT_CTL_BASE
                   && 32'(reg_addr[7:2]) < NUM_PORTS;
        wr_partition_select  = reg_wr && reg_addr >= spr_pkg::ADDR_PARTITION_SELECT_CTL_BASE
                   && reg_addr < spr_pkg::ADDR_TIMER_SE
                   && 32'(reg_addr[5:2]) < NUM_PARTS;
        widx     = reg_addr[5:2];
        new_mode = reg_wdata[spr_pkg::PC_MODE_LSB +: 3];
        new_mca  = reg_wdata[spr_pkg::PC_MCA_LSB +: 2];
        mode_d = mode_q;
        partition_select_d = partition_select_q;
        mca_d  = mca_q;
        pstate_d = pstate_q;
        tmr_d  = tmr_q;
        cap_pm_d = cap_pm_q;
        cap_vc_d = cap_vc_q;
        state_d = state_q;
        cnt_d   = cnt_q;
        tgt_d   = tgt_q;
        tgt_rst_d = tgt_rst_q;
        down_d  = down_q;
        en_d    = en_q;
        up_d    = up_q;
        retr_d  = retr_q;
        retr_cnt_d = retr_cnt_q;

        // writes other than the retrain bit accepted only when idle so one change runs at a time
        if (wr_port && state_q == spr_pkg::SPR_IDLE) begin
            mode_d[widx] = new_mode;
            partition_select_d[widx] = reg_wdata[spr_pkg::PC_PARTITION_SELECT_LSB +: 3];
            mca_d[widx]  = new_mca;
            if (new_mode != mode_q[widx]) begin
                state_d   = spr_pkg::SPR_WAIT;
                tgt_d     = widx;
                tgt_rst_d = new_mca == spr_pkg::MCA_RESET;
                cnt_d     = (new_mca == spr_pkg::MCA_RESET) ? MC_RST_CYC - 1
                                                             : MC_NORM_CYC - 1;
                // upstream role involved and reset action: drop the link
                if (new_mca == spr_pkg::MCA_RESET &&
                    (new_mode == spr_pkg::MODE_UPSTREAM ||
                     mode_q[widx] == spr_pkg::MODE_UPSTREAM)) begin
                    down_d[widx] = 1'b1;
                end
            end
        end
        if (wr_port && reg_wdata[spr_pkg::PC_FLR_BIT]) begin
            retr_d[widx]     = 1'b1;
            retr_cnt_d[widx] = 5'(spr_pkg::RETRAIN_CYC - 1);
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (retr_q[p] && !(wr_port && widx == 4'(p))) begin
                if (retr_cnt_q[p] == 5'h0_0) retr_d[p] = 1'b0;
                else retr_cnt_d[p] = retr_cnt_q[p] - 5'h0_1;
            end
        end
        if (wr_partition_select && state_q == spr_pkg::SPR_IDLE) begin
            pstate_d[reg_addr[4:2]] = reg_wdata[0];
            state_d = spr_pkg::SPR_WAIT;
            tgt_d   = 4'h0;
            tgt_rst_d = 1'b0;
            // a partition that loses or gains active state waits out the mode-change latency
            // of its enabled ports; otherwise it settles in a few cycles
            cnt_d = spr_pkg::PARTITION_SELECT_STATE_CYC - 1;
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (partition_select_q[p] == reg_addr[4:2] && mode_q[p] != spr_pkg::MODE_DISABLED
                    && reg_wdata[0] != pstate_q[reg_addr[4:2]]) begin
                    // several ports may move: the longest latency wins
                    if (mca_q[p] == spr_pkg::MCA_RESET) begin
                        if (cnt_d < MC_RST_CYC - 1) cnt_d = MC_RST_CYC - 1;
                    end else if (cnt_d < MC_NORM_CYC - 1) begin
                        cnt_d = MC_NORM_CYC - 1;
                    end
                end
            end
        end
        if (reg_wr && state_q == spr_pkg::SPR_IDLE) begin
            case (reg_addr)
                spr_pkg::ADDR_TIMER_SE:    tmr_d[0] = reg_wdata[15:0];
                spr_pkg::ADDR_TIMER_MCD:   tmr_d[1] = reg_wdata[15:0];
                spr_pkg::ADDR_TIMER_RD:    tmr_d[2] = reg_wdata[15:0];
                spr_pkg::ADDR_TIMER_USSBR: tmr_d[3] = reg_wdata[15:0];
                spr_pkg::ADDR_CAP_PM:      cap_pm_d = reg_wdata[7:0];
                spr_pkg::ADDR_CAP_VC:      cap_vc_d = reg_wdata[7:0];
                default: ;
            endcase
        end

        case (state_q)
            spr_pkg::SPR_IDLE: ;
            spr_pkg::SPR_WAIT: begin
                if (cnt_q == 32'h0000_0000) state_d = spr_pkg::SPR_DONE;
                else cnt_d = cnt_q - 32'h0000_0001;
            end
            spr_pkg::SPR_DONE: begin
                // role takes effect only once the latency has run out
                for (int p = 0; p < NUM_PORTS; p++) begin
                    en_d[p] = mode_q[p] != spr_pkg::MODE_DISABLED;
                    up_d[p] = mode_q[p] == spr_pkg::MODE_UPSTREAM;
                end
                if (tgt_rst_q) down_d[tgt_q] = 1'b0;
                state_d = spr_pkg::SPR_IDLE;
            end
            default: state_d = spr_pkg::SPR_IDLE;
        endcase

        busy_d = state_d != spr_pkg::SPR_IDLE;

        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr < spr_pkg::ADDR_PARTITION_SELECT_CTL_BASE && 32'(reg_addr[7:2]) < NUM_PORTS) begin
                rdata_d[spr_pkg::PC_MODE_LSB +: 3] = mode_q[reg_addr[5:2]];
                rdata_d[spr_pkg::PC_PARTITION_SELECT_LSB +: 3] = partition_select_q[reg_addr[5:2]];
                rdata_d[spr_pkg::PC_MCA_LSB +: 2]  = mca_q[reg_addr[5:2]];
                rdata_d[spr_pkg::PC_FLR_BIT]       = retr_q[reg_addr[5:2]];
            end else if (reg_addr >= spr_pkg::ADDR_PARTITION_SELECT_CTL_BASE
                         && reg_addr < spr_pkg::ADDR_TIMER_SE) begin
                if (32'(reg_addr[5:2]) < NUM_PARTS) rdata_d[0] = pstate_q[reg_addr[4:2]];
            end else begin
                case (reg_addr)
                    spr_pkg::ADDR_TIMER_SE:    rdata_d[15:0] = tmr_q[0];
                    spr_pkg::ADDR_TIMER_MCD:   rdata_d[15:0] = tmr_q[1];
                    spr_pkg::ADDR_TIMER_RD:    rdata_d[15:0] = tmr_q[2];
                    spr_pkg::ADDR_TIMER_USSBR: rdata_d[15:0] = tmr_q[3];
                    spr_pkg::ADDR_STATUS:      rdata_d[0] = state_q != spr_pkg::SPR_IDLE;
                    spr_pkg::ADDR_CAP_PM:      rdata_d[7:0] = cap_pm_q;
                    spr_pkg::ADDR_CAP_VC:      rdata_d[7:0] = cap_vc_q;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                mode_q[p]     <= spr_pkg::MODE_DISABLED;
                partition_select_q[p]     <= 3'h0;
                mca_q[p]      <= spr_pkg::MCA_NONE;
                retr_cnt_q[p] <= 5'h0_0;
            end
            for (int q = 0; q < NUM_PARTS; q++) pstate_q[q] <= 1'b0;
            tmr_q[0]  <= spr_pkg::TIMER_SE_RST;
            tmr_q[1]  <= spr_pkg::TIMER_MCD_RST;
            tmr_q[2]  <= spr_pkg::TIMER_RD_RST;
            tmr_q[3]  <= spr_pkg::TIMER_USSBR_RST;
            cap_pm_q  <= spr_pkg::CAP_PTR_RST;
            cap_vc_q  <= spr_pkg::CAP_PTR_RST;
            rdata_q   <= 32'h0000_0000;
            state_q   <= spr_pkg::SPR_IDLE;
            cnt_q     <= 32'h0000_0000;
            tgt_q     <= 4'h0;
            tgt_rst_q <= 1'b0;
            down_q    <= '0;
            en_q      <= '0;
            up_q      <= '0;
            retr_q    <= '0;
            busy_q    <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            partition_select_q    <= partition_select_d;
            mca_q     <= mca_d;
            retr_cnt_q <= retr_cnt_d;
            pstate_q  <= pstate_d;
            tmr_q     <= tmr_d;
            cap_pm_q  <= cap_pm_d;
            cap_vc_q  <= cap_vc_d;
            rdata_q   <= rdata_d;
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            tgt_q     <= tgt_d;
            tgt_rst_q <= tgt_rst_d;
            down_q    <= down_d;
            en_q      <= en_d;
            up_q      <= up_d;
            retr_q    <= retr_d;
            busy_q    <= busy_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign link_down           = down_q;
    assign link_retrain_detect = retr_q;
    assign port_enabled        = en_q;
    assign port_is_upstream    = up_q;
    assign reconfig_busy       = busy_q;

endmodule

/* design/spr_pkg.sv */
// spr_pkg: constants for the switch partition reconfiguration block.
// assumes a 200 MHz core clock and a plain strobe register port.
package spr_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam int unsigned MC_NO_RESET_US    = 2000;  // 2 ms, no-reset action
    localparam int unsigned MC_RESET_US       = 2500;  // 2.5 ms, reset action
    localparam int unsigned MC_NO_RESET_CYC   = MC_NO_RESET_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned MC_RESET_CYC      = MC_RESET_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned PARTITION_SELECT_STATE_CYC    = 4;     // plain partition state change
    localparam int unsigned RETRAIN_CYC       = 16;    // detect pulse hold on retrain

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_PORT_CTL_BASE = 8'h00; // port p at base + 4*p
    localparam logic [7:0] ADDR_PARTITION_SELECT_CTL_BASE = 8'h40; // partition q at base + 4*q
    localparam logic [7:0] ADDR_TIMER_SE      = 8'h80;
    localparam logic [7:0] ADDR_TIMER_MCD     = 8'h84;
    localparam logic [7:0] ADDR_TIMER_RD      = 8'h88;
    localparam logic [7:0] ADDR_TIMER_USSBR   = 8'h8C;
    localparam logic [7:0] ADDR_STATUS        = 8'h90;
    localparam logic [7:0] ADDR_CAP_PM        = 8'h94;
    localparam logic [7:0] ADDR_CAP_VC        = 8'h98;

    // ****************************************************************
    // port control fields
    // ****************************************************************
    localparam int unsigned PC_MODE_LSB  = 0;   // 3 bits operating mode
    localparam int unsigned PC_PARTITION_SELECT_LSB  = 4;   // 3 bits partition select
    localparam int unsigned PC_MCA_LSB   = 8;   // 2 bits mode change action
    localparam int unsigned PC_FLR_BIT   = 12;  // full link retrain, self clearing

    localparam logic [2:0] MODE_DISABLED   = 3'h0;
    localparam logic [2:0] MODE_DOWNSTREAM = 3'h1;
    localparam logic [2:0] MODE_UPSTREAM   = 3'h2;
    localparam logic [1:0] MCA_NONE        = 2'h0;
    localparam logic [1:0] MCA_RESET       = 2'h1;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] TIMER_SE_RST    = 16'h0000;
    localparam logic [15:0] TIMER_MCD_RST   = 16'h0000;
    localparam logic [15:0] TIMER_RD_RST    = 16'h0000;
    localparam logic [15:0] TIMER_USSBR_RST = 16'h0000;
    localparam logic [7:0]  CAP_PTR_RST     = 8'h00;

    typedef enum logic [2:0] {
        SPR_IDLE = 3'b001,
        SPR_WAIT = 3'b010,
        SPR_DONE = 3'b100
    } spr_state_t;

endpackage

/* bench/spr_checker.sv */
// spr_checker: port-level assertions for the reconfiguration block.
// assumes a bind onto spr_switch_partition_reconfig with 16 ports.
`timescale 1ns/100ps
module spr_checker #(
    parameter int unsigned NUM_PORTS   = 16,
    parameter int unsigned NUM_PARTS   = 8,
    parameter int unsigned MC_NORM_CYC = spr_pkg::MC_NO_RESET_CYC,
    parameter int unsigned MC_RST_CYC  = spr_pkg::MC_RESET_CYC
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset_n,
    // register port
    input wire logic [7:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // link control
    input wire logic [NUM_PORTS-1:0] link_down,
    input wire logic [NUM_PORTS-1:0] link_retrain_detect,
    input wire logic [NUM_PORTS-1:0] port_enabled,
    input wire logic [NUM_PORTS-1:0] port_is_upstream,
    input wire logic                 reconfig_busy
);
    // ****************************************
    // helpers
    // ****************************************
    logic [31:0] busy_len;
    logic [3:0] idx;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic       pw;
    logic       mc;
    // current mode is inferred from the role outputs, valid while idle
    assign idx = reg_addr[5:2];
    assign cur = port_is_upstream[idx] ? 3'h2 : {2'h0, port_enabled[idx]};
    assign nxt = reg_wdata[2:0];
    assign pw  = reg_wr && reg_addr < 8'h40 && reg_addr[1:0] == 2'h0;
    assign mc  = pw && !reconfig_busy && nxt <= 3'h2 && nxt != cur;
    // busy run length, so the bound follows the latency parameter
    always_ff @(posedge clk) begin
        if (!reset_n || !reconfig_busy) busy_len <= 32'h0000_0000;
        else busy_len <= busy_len + 32'h0000_0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // assertions
    // ****************************************
    reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> reg_rdata == '0
        && port_enabled == '0 && link_down == '0 && !reconfig_busy) else $error("reset not clear");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside read slot");
    mode_busy_a: assert property (mc |=> reconfig_busy [*8])
        else $error("mode write did not start reconfiguration");
    busy_bound_a: assert property (reconfig_busy |-> busy_len <= MC_RST_CYC)
        else $error("reconfiguration ran past its latency");
    down_set_a: assert property (mc && reg_wdata[9:8] == spr_pkg::MCA_RESET
        && (nxt == spr_pkg::MODE_UPSTREAM || cur == spr_pkg::MODE_UPSTREAM)
        |=> link_down[$past(idx)]) else $error("upstream link not taken down");
    down_none_a: assert property (mc && reg_wdata[9:8] == spr_pkg::MCA_NONE
        |=> !link_down[$past(idx)]) else $error("link down without reset action");
    down_busy_a: assert property (link_down != '0 |-> reconfig_busy)
        else $error("link down outside reconfiguration");
    role_change_a: assert property ($changed({port_enabled, port_is_upstream})
        |-> $past(reconfig_busy) && !reconfig_busy) else $error("role changed off completion");
    retrain_a: assert property (pw && reg_wdata[12] |=> ##[0:2] link_retrain_detect != '0)
        else $error("retrain not started");
    partition_select_fast_a: assert property (reg_wr && reg_addr[7:5] == 3'h2 && !reconfig_busy
        && port_enabled == '0 |=> ##[0:6] !reconfig_busy) else $error("slow partition change");
endmodule

bind spr_switch_partition_reconfig spr_checker #(.NUM_PORTS(NUM_PORTS), .NUM_PARTS(NUM_PARTS),
    .MC_NORM_CYC(MC_NORM_CYC), .MC_RST_CYC(MC_RST_CYC)) i_spr_checker (.clk, .reset_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_down, .link_retrain_detect,
    .port_enabled, .port_is_upstream, .reconfig_busy);

/* bench/tb.sv */
// tb: self-checking bench for the partition reconfiguration block.
// assumes short mode-change counts so a run stays a few hundred cycles.
`timescale 1ns/100ps
module tb;
    localparam int NP = 16;
    localparam int MN = 20;
    localparam int MR = 25;
    logic            clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [31:0]     reg_wdata = 32'h0000_0000, reg_rdata, r;
    logic [NP-1:0]   link_down, link_retrain_detect, port_enabled, port_is_upstream;
    logic            reconfig_busy;
    int              n_errors = 0, tests_run = 0, cyc = 0, n, p, seed = 32'h04205d7d;
    int              mdl_mode[NP];
    logic [15:0]     trst[4] = '{spr_pkg::TIMER_SE_RST, spr_pkg::TIMER_MCD_RST,
                                 spr_pkg::TIMER_RD_RST, spr_pkg::TIMER_USSBR_RST};
    always #2.5 clk = ~clk;
    spr_switch_partition_reconfig #(.NUM_PORTS(NP), .NUM_PARTS(8), .MC_NORM_CYC(MN),
        .MC_RST_CYC(MR)) i_spr_switch_partition_reconfig (.clk, .reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_down, .link_retrain_detect,
        .port_enabled, .port_is_upstream, .reconfig_busy);
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string what);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata & m, e);
    endtask
    // counts busy cycles after a write; bounded so a stuck sequencer cannot hang
    task automatic wait_idle();
        n = 0;
        while (reconfig_busy !== 1'b0 && n < 200) begin @(posedge clk); #1 n++; end
    endtask
    task automatic cmp_ports();
        logic [NP-1:0] en, up;
        for (int i = 0; i < NP; i++) begin en[i] = mdl_mode[i] != 0; up[i] = mdl_mode[i] == 2; end
        chk("port_enabled", port_enabled, en);
        chk("port_is_upstream", port_is_upstream, up);
        chk("link_down_idle", link_down, '0);
    endtask
    task automatic port(int q, int md, int pt, int act);
        int lat;
        lat = act == 1 ? MR : MN;
        wr(8'(4 * q), 32'(md | pt << 4 | act << 8));
        #1;
        chk("busy_start", reconfig_busy, md != mdl_mode[q]);
        if (md != mdl_mode[q]) begin
            chk("link_down", link_down[q], act == 1 && (md == 2 || mdl_mode[q] == 2));
            wait_idle();
            chk("latency", n >= lat && n <= lat + 3, 1);
        end
        mdl_mode[q] = md;
        cmp_ports();
        rd(8'(4 * q), 32'h0000_1377, 32'(md | pt << 4 | act << 8), "port_ctl");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin n_errors++; results(); end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        foreach (mdl_mode[i]) mdl_mode[i] = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1; // only reset_n, no partition reset pin in use
        #1 cmp_ports();
        rd(8'h90, 32'hffff_ffff, 32'h0, "status");
        rd(8'hfc, 32'hffff_ffff, 32'h0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'(8'h80 + 4 * i), 32'h0);
            rd(8'(8'h80 + 4 * i), 32'h0000_ffff, 32'h0, "timer_zero");
        end
        for (int i = 0; i < 2; i++) begin
            r = 32'($random(seed)) & 32'h0000_00ff;
            wr(8'(8'h94 + 4 * i), r);
            rd(8'(8'h94 + 4 * i), 32'h0000_00ff, r, "cap_ptr");
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'(8'h40 + 4 * i), 32'h1);
            #1 wait_idle();
            chk("partition_select_fast", n <= spr_pkg::PARTITION_SELECT_STATE_CYC + 2, 1);
            rd(8'(8'h40 + 4 * i), 32'h1, 32'h1, "partition_select_state");
        end
        $display("test setup done");
        port(1, 1, 0, 0);
        for (int i = 2; i < 6; i++) port(i, 1, $random(seed) & 1, 0);
        port(8, 2, 0, 0);
        port(9, 2, 1, 1);
        port(8, 0, 0, 1);
        port(3, 0, 1, 0);
        port(10, 1, 1, 0);
        port(10, 1, 0, 0);
        $display("test modes done");
        wr(8'h2c, 32'h1);
        wr(8'h30, 32'h1);
        wait_idle();
        mdl_mode[11] = 1;
        cmp_ports();
        $display("test refused done");
        wr(8'h08, 32'h0000_1001);
        #1 n = 0;
        repeat (30) begin n += link_retrain_detect[2]; @(posedge clk); #1; end
        chk("retrain_len", n, spr_pkg::RETRAIN_CYC);
        rd(8'h08, 32'h0000_1000, 32'h0, "retrain_clear");
        for (int i = 0; i < 4; i++) begin
            r = 32'($random(seed)) & 32'h0000_ffff;
            wr(8'(8'h80 + 4 * i), r);
            rd(8'(8'h80 + 4 * i), 32'h0000_ffff, r, "timer_rw");
            wr(8'(8'h80 + 4 * i), 32'(trst[i]));
            rd(8'(8'h80 + 4 * i), 32'h0000_ffff, 32'(trst[i]), "timer_dflt");
        end
        chk("setup_time", cyc - 16 < 200000000, 1);
        wr(8'h40, 32'h0);
        #1 wait_idle();
        chk("partition_select_slow", n >= MN && n <= MR + 3, 1);
        $display("test partition done");
        results();
    end
endmodule
